// *** rtl/tse_pkg.sv ***
// Constants for the timer software event generation block.
// Assumes a 32-bit APB register bus and a 40 MHz kernel clock.
package tse_pkg;
	localparam int TSE_NCH = 4;
	localparam int TSE_CNT_W = 16;
	localparam int TSE_ADDR_W = 8;
	localparam int TSE_DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] TSE_ADDR_CTRL = 8'h00;
	localparam logic [7:0] TSE_ADDR_MASK = 8'h0C;
	localparam logic [7:0] TSE_ADDR_STATUS = 8'h10;
	localparam logic [7:0] TSE_ADDR_EVTGEN = 8'h14;
	localparam logic [7:0] TSE_ADDR_CAP1 = 8'h20;
	localparam logic [7:0] TSE_ADDR_CAP4 = 8'h2C;

	// Event generation register bits
	localparam int TSE_EVT_W = 8;
	localparam int TSE_EVT_UPD = 0;
	localparam int TSE_EVT_CH1 = 1;
	localparam int TSE_EVT_COM = 5;
	localparam int TSE_EVT_TRG = 6;
	localparam int TSE_EVT_BRK = 7;
	localparam logic [7:0] TSE_EVT_RST = 8'h00;

	// Status and mask layout; overcapture of channel i sits at TSE_STS_OVC1 + i
	localparam int TSE_STS_W = 13;
	localparam int TSE_STS_UPD = 0;
	localparam int TSE_STS_CH1 = 1;
	localparam int TSE_STS_COM = 5;
	localparam int TSE_STS_TRG = 6;
	localparam int TSE_STS_BRK = 7;
	localparam int TSE_STS_OVC1 = 9;
	localparam logic [12:0] TSE_STS_RST = 13'h0000;

	// Control register layout
	localparam int TSE_CTRL_W = 12;
	localparam int TSE_CTRL_UPDATE_DISABLE = 0;
	localparam int TSE_CTRL_UPDATE_SOURCE_SELECT = 1;
	localparam int TSE_CTRL_CCPC = 2;
	localparam int TSE_CTRL_DOWN = 3;
	localparam int TSE_CTRL_CMS_LO = 4;
	localparam int TSE_CTRL_CMS_HI = 5;
	localparam int TSE_CTRL_IN1 = 8;
	localparam logic [11:0] TSE_CTRL_RST = 12'h000;

	// Channels that own complementary outputs
	localparam logic [3:0] TSE_COMP_MASK = 4'h7;
	localparam logic [15:0] TSE_CNT_ZERO = 16'h0000;
	localparam logic [31:0] TSE_DATA_ZERO = 32'h0000_0000;

	typedef enum logic
	{
		TSE_SLV_IDLE = 1'b0,
		TSE_SLV_ACK = 1'b1
	} tse_slv_e;
endpackage : tse_pkg

// *** rtl/tse_reg_if.sv ***
// Internal register access bus between the APB slave and the core.
// Assumes both ends run on clk_sys.
interface tse_reg_if;
	import tse_pkg::*;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic err;

	modport slave
	(
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input rdata,
		input err
	);
	modport core
	(
		input wr_en,
		input rd_en,
		input addr,
		input wdata,
		output rdata,
		output err
	);
endinterface : tse_reg_if

// *** rtl/tse_apb_slave.sv ***
// APB slave front end: one wait state, registered pready, prdata and pslverr.
// Assumes a well-behaved APB master on clk_sys.
module tse_apb_slave
	import tse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	tse_reg_if.slave bus
);
	tse_slv_e state_ff;
	tse_slv_e nxt_state;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	always_comb
	begin
		nxt_state = TSE_SLV_IDLE;
		if (state_ff == TSE_SLV_IDLE && psel && penable)
		begin
			nxt_state = TSE_SLV_ACK;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_ff <= TSE_SLV_IDLE;
			pready_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pready_ff <= (nxt_state == TSE_SLV_ACK);
		end
	end

	// Read data is sampled one cycle before completion so it comes from a flop
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			prdata_ff <= TSE_DATA_ZERO;
			pslverr_ff <= 1'b0;
		end
		else if (nxt_state == TSE_SLV_ACK)
		begin
			prdata_ff <= pwrite ? TSE_DATA_ZERO : bus.rdata;
			pslverr_ff <= bus.err;
		end
		else
		begin
			prdata_ff <= TSE_DATA_ZERO;
			pslverr_ff <= 1'b0;
		end
	end

	// Register side effects happen only at the completing edge
	assign bus.wr_en = psel && penable && pwrite && pready_ff;
	assign bus.rd_en = psel && penable && !pwrite && pready_ff;
	assign bus.addr = paddr;
	assign bus.wdata = pwdata;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
endmodule : tse_apb_slave

// *** rtl/tse_chan.sv ***
// One capture/compare channel: flag, overcapture flag and capture register.
// Assumes req is a one-cycle pulse and clears are one-cycle pulses.
module tse_chan
	import tse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic req,
	input wire logic input_mode,
	input wire logic [15:0] cnt_value,
	input wire logic flag_clr,
	input wire logic ovc_clr,
	output logic flag,
	output logic ovc,
	output logic [15:0] cap
);
	logic flag_ff;
	logic ovc_ff;
	logic [15:0] cap_ff;

	// Set beats a clear landing in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			flag_ff <= 1'b0;
		end
		else
		begin
			flag_ff <= (flag_ff && !flag_clr) || req;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			ovc_ff <= 1'b0;
		end
		else
		begin
			ovc_ff <= (ovc_ff && !ovc_clr) || (req && input_mode && flag_ff);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			cap_ff <= TSE_CNT_ZERO;
		end
		else if (req && input_mode)
		begin
			cap_ff <= cnt_value;
		end
	end

	assign flag = flag_ff;
	assign ovc = ovc_ff;
	assign cap = cap_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	ovc_set_a: assert property (req && input_mode && flag_ff |=> ovc_ff)
		else $error("overcapture not flagged");
	no_ovc_out_a: assert property (req && !input_mode && !ovc_ff && !ovc_clr |=> !ovc_ff)
		else $error("overcapture in output mode");
endmodule : tse_chan

// *** rtl/tse_top.sv ***
// Software event generation for an advanced control timer, with APB access.
// Assumes the counter, channel output and break units consume the event pulses.
//
// Implementation choice: the APB register port.
module tse_top
	import tse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] cnt_value,
	input wire logic [15:0] auto_reload_value,
	output logic irq,
	output logic main_output_enable_clr,
	output logic trigger_event,
	output logic [3:0] com_update_ch,
	output logic [3:0] cc_event,
	output logic cnt_load,
	output logic [15:0] cnt_load_value,
	output logic presc_clear
);
	tse_reg_if bus();

	logic [7:0] evt_req_ff;
	logic [11:0] ctrl_ff;
	logic [12:0] mask_ff;
	logic upd_flag_ff;
	logic com_flag_ff;
	logic trg_flag_ff;
	logic brk_flag_ff;
	logic irq_ff;
	logic moe_clr_ff;
	logic trg_evt_ff;
	logic [3:0] com_upd_ff;
	logic [3:0] cc_evt_ff;
	logic cnt_load_ff;
	logic [15:0] cnt_load_value_ff;
	logic presc_clear_ff;
	logic [3:0] ch_flag;
	logic [3:0] ch_ovc;
	logic [15:0] ch_cap [TSE_NCH];
	logic [3:0] ch_rd_clr;
	logic [12:0] status;
	logic [12:0] sts_clr;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_status;
	logic wr_evt;
	logic [11:0] in_mode_bits;

	tse_apb_slave u_slave
	(
		.clk_sys(clk_sys),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus(bus)
	);

	assign wr_ctrl = bus.wr_en && bus.addr == TSE_ADDR_CTRL;
	assign wr_mask = bus.wr_en && bus.addr == TSE_ADDR_MASK;
	assign wr_status = bus.wr_en && bus.addr == TSE_ADDR_STATUS;
	assign wr_evt = bus.wr_en && bus.addr == TSE_ADDR_EVTGEN;
	assign sts_clr = wr_status ? bus.wdata[TSE_STS_W-1:0] : TSE_STS_RST;
	assign in_mode_bits = ctrl_ff;

	assign status = {ch_ovc, 1'b0, brk_flag_ff, trg_flag_ff, com_flag_ff, ch_flag, upd_flag_ff};

	// Read mux and unmapped-address answer
	always_comb
	begin
		bus.rdata = TSE_DATA_ZERO;
		bus.err = 1'b0;
		unique case (bus.addr)
			TSE_ADDR_CTRL: bus.rdata = {20'h0_0000, ctrl_ff};
			TSE_ADDR_MASK: bus.rdata = {19'h0_0000, mask_ff};
			TSE_ADDR_STATUS: bus.rdata = {19'h0_0000, status};
			TSE_ADDR_EVTGEN: bus.rdata = TSE_DATA_ZERO;
			TSE_ADDR_CAP1: bus.rdata = {16'h0000, ch_cap[0]};
			TSE_ADDR_CAP1 + 8'h04: bus.rdata = {16'h0000, ch_cap[1]};
			TSE_ADDR_CAP1 + 8'h08: bus.rdata = {16'h0000, ch_cap[2]};
			TSE_ADDR_CAP4: bus.rdata = {16'h0000, ch_cap[3]};
			default: bus.err = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			ctrl_ff <= TSE_CTRL_RST;
		end
		else if (wr_ctrl)
		begin
			ctrl_ff <= bus.wdata[TSE_CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			mask_ff <= TSE_STS_RST;
		end
		else if (wr_mask)
		begin
			mask_ff <= bus.wdata[TSE_STS_W-1:0];
		end
	end

	// Requests live for exactly one cycle; zeros and reserved bits are dropped
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			evt_req_ff <= TSE_EVT_RST;
		end
		else
		begin
			evt_req_ff <= wr_evt ? bus.wdata[TSE_EVT_W-1:0] : TSE_EVT_RST;
		end
	end

	// Hardware-set status flags, write one to clear, set wins
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			upd_flag_ff <= 1'b0;
			com_flag_ff <= 1'b0;
			trg_flag_ff <= 1'b0;
			brk_flag_ff <= 1'b0;
		end
		else
		begin
			upd_flag_ff <= (upd_flag_ff && !sts_clr[TSE_STS_UPD]) || (evt_req_ff[TSE_EVT_UPD]
				&& !ctrl_ff[TSE_CTRL_UPDATE_SOURCE_SELECT] && !ctrl_ff[TSE_CTRL_UPDATE_DISABLE]);
			com_flag_ff <= (com_flag_ff && !sts_clr[TSE_STS_COM]) || evt_req_ff[TSE_EVT_COM];
			trg_flag_ff <= (trg_flag_ff && !sts_clr[TSE_STS_TRG]) || evt_req_ff[TSE_EVT_TRG];
			brk_flag_ff <= (brk_flag_ff && !sts_clr[TSE_STS_BRK]) || evt_req_ff[TSE_EVT_BRK];
		end
	end

	// Reading a capture register also clears that channel's flag
	genvar gi;
	generate
		for (gi = 0; gi < TSE_NCH; gi++)
		begin : g_ch
			assign ch_rd_clr[gi] = bus.rd_en && bus.addr == TSE_ADDR_CAP1 + 8'(4 * gi);
			tse_chan u_chan
			(
				.clk_sys(clk_sys),
				.resetn(resetn),
				.req(evt_req_ff[TSE_EVT_CH1 + gi]),
				.input_mode(in_mode_bits[TSE_CTRL_IN1 + gi]),
				.cnt_value(cnt_value),
				.flag_clr(sts_clr[TSE_STS_CH1 + gi] || ch_rd_clr[gi]),
				.ovc_clr(sts_clr[TSE_STS_OVC1 + gi]),
				.flag(ch_flag[gi]),
				.ovc(ch_ovc[gi]),
				.cap(ch_cap[gi])
			);
		end
	endgenerate

	// Event strobes towards break, slave and channel units
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			moe_clr_ff <= 1'b0;
			trg_evt_ff <= 1'b0;
			com_upd_ff <= 4'h0;
			cc_evt_ff <= 4'h0;
		end
		else
		begin
			moe_clr_ff <= evt_req_ff[TSE_EVT_BRK];
			trg_evt_ff <= evt_req_ff[TSE_EVT_TRG];
			// Preloaded enables and modes move only under preload control
			com_upd_ff <= (evt_req_ff[TSE_EVT_COM] && ctrl_ff[TSE_CTRL_CCPC]) ? TSE_COMP_MASK : 4'h0;
			// Output-mode channels only; input-mode ones capture instead
			cc_evt_ff <= evt_req_ff[TSE_EVT_CH1 +: TSE_NCH] & ~in_mode_bits[TSE_CTRL_IN1 +: TSE_NCH];
		end
	end

	// Counter reload is not gated by update disable: the request always reinitialises
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			cnt_load_ff <= 1'b0;
			presc_clear_ff <= 1'b0;
			cnt_load_value_ff <= TSE_CNT_ZERO;
		end
		else
		begin
			cnt_load_ff <= evt_req_ff[TSE_EVT_UPD];
			presc_clear_ff <= evt_req_ff[TSE_EVT_UPD];
			if (evt_req_ff[TSE_EVT_UPD])
			begin
				cnt_load_value_ff <= (ctrl_ff[TSE_CTRL_DOWN]
					&& ctrl_ff[TSE_CTRL_CMS_HI:TSE_CTRL_CMS_LO] == 2'b00) ? auto_reload_value : TSE_CNT_ZERO;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= |(status & mask_ff);
		end
	end

	assign irq = irq_ff;
	assign main_output_enable_clr = moe_clr_ff;
	assign trigger_event = trg_evt_ff;
	assign com_update_ch = com_upd_ff;
	assign cc_event = cc_evt_ff;
	assign cnt_load = cnt_load_ff;
	assign cnt_load_value = cnt_load_value_ff;
	assign presc_clear = presc_clear_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	brk_moe_a: assert property (evt_req_ff[TSE_EVT_BRK] |=> moe_clr_ff && brk_flag_ff)
		else $error("break did not clear output enable");
	req_clear_a: assert property (evt_req_ff != 8'h00 |=> evt_req_ff == 8'h00)
		else $error("request bit did not clear");
	zero_write_a: assert property (wr_evt && bus.wdata[7:0] == 8'h00 |=> evt_req_ff == 8'h00 ##1 !cnt_load_ff)
		else $error("zero write caused an event");
	trg_flag_a: assert property (evt_req_ff[TSE_EVT_TRG] |=> trg_flag_ff && trg_evt_ff)
		else $error("trigger flag not set");
	com_load_a: assert property (evt_req_ff[TSE_EVT_COM]
		|=> com_upd_ff == ($past(ctrl_ff[TSE_CTRL_CCPC]) ? TSE_COMP_MASK : 4'h0))
		else $error("commutation preload wrong");
	com_mask_a: assert property ((com_upd_ff & ~TSE_COMP_MASK) == 4'h0)
		else $error("commutation hit non-complementary channel");
	cc_flag_a: assert property (evt_req_ff[TSE_EVT_CH1] && !ctrl_ff[TSE_CTRL_IN1] |=> ch_flag[0] && cc_evt_ff[0])
		else $error("channel event flag missing");
	cap_value_a: assert property (evt_req_ff[TSE_EVT_CH1 + 1] && ctrl_ff[TSE_CTRL_IN1 + 1]
		|=> ch_cap[1] == $past(cnt_value) && ch_flag[1] && !cc_evt_ff[1])
		else $error("capture value wrong");
	upd_load_a: assert property (evt_req_ff[TSE_EVT_UPD] |=> cnt_load_ff && presc_clear_ff ##1 !cnt_load_ff)
		else $error("update did not reinitialise");
	upd_value_a: assert property (evt_req_ff[TSE_EVT_UPD] |=> cnt_load_value_ff ==
		(($past(ctrl_ff[TSE_CTRL_DOWN]) && $past(ctrl_ff[TSE_CTRL_CMS_HI:TSE_CTRL_CMS_LO]) == 2'b00)
		? $past(auto_reload_value) : TSE_CNT_ZERO))
		else $error("update load value wrong");
	upd_flag_a: assert property (evt_req_ff[TSE_EVT_UPD]
		|=> upd_flag_ff == ($past(upd_flag_ff) || ($past(ctrl_ff[1:0]) == 2'b00)))
		else $error("update flag gating wrong");
	evt_read_a: assert property (psel && penable && !pwrite && pready && paddr == TSE_ADDR_EVTGEN
		|-> prdata == TSE_DATA_ZERO)
		else $error("event register read nonzero");
	brk_pulse_a: assert property (!evt_req_ff[TSE_EVT_BRK] |=> !moe_clr_ff)
		else $error("break pulse without request");
	com_flag_a: assert property (evt_req_ff[TSE_EVT_COM] |=> com_flag_ff)
		else $error("commutation flag not set");
	trg_pulse_a: assert property (!evt_req_ff[TSE_EVT_TRG] |=> !trg_evt_ff)
		else $error("trigger pulse stretched");
	upd_pulse_a: assert property (!evt_req_ff[TSE_EVT_UPD] |=> !cnt_load_ff && !presc_clear_ff)
		else $error("update pulse stretched");
	irq_level_a: assert property (irq_ff == $past(|(status & mask_ff)))
		else $error("interrupt level wrong");

	brk_c: cover property (evt_req_ff[TSE_EVT_BRK] ##2 irq_ff);
	com_c: cover property (evt_req_ff[TSE_EVT_COM] && ctrl_ff[TSE_CTRL_CCPC]);
	ovc_c: cover property (|ch_ovc);
	upd_down_c: cover property (evt_req_ff[TSE_EVT_UPD] && ctrl_ff[TSE_CTRL_DOWN]);
	cap_in_c: cover property (evt_req_ff[TSE_EVT_CH1] && ctrl_ff[TSE_CTRL_IN1]);
endmodule : tse_top

// *** verif/tse_top_tb.sv ***
// Testbench for tse_top: APB register access plus counter inputs, watching event pulses.
// Assumes the design answers each APB access within a few cycles of the access phase.
module tse_top_tb
	import tse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [15:0] cnt_value = 16'h0000;
	logic [15:0] auto_reload_value = 16'h0000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, main_output_enable_clr, trigger_event, cnt_load, presc_clear;
	logic [3:0] com_update_ch, cc_event, cc_seen, com_seen;
	logic [15:0] cnt_load_value, load_seen;
	logic [31:0] rdat;
	logic rerr;
	int n_fail = 0;
	int samples_checked = 0;
	int n_brk, n_trg, n_upd, n_presc, n_cc, n_com;

	always #12.5 clk_sys = ~clk_sys;

	tse_top dut
	(
		.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cnt_value(cnt_value), .auto_reload_value(auto_reload_value), .irq(irq),
		.main_output_enable_clr(main_output_enable_clr), .trigger_event(trigger_event),
		.com_update_ch(com_update_ch), .cc_event(cc_event), .cnt_load(cnt_load),
		.cnt_load_value(cnt_load_value), .presc_clear(presc_clear)
	);

	// Counting high cycles catches pulses that stretch or repeat
	always @(posedge clk_sys)
	begin
		if (main_output_enable_clr === 1'b1) n_brk++;
		if (trigger_event === 1'b1) n_trg++;
		if (presc_clear === 1'b1) n_presc++;
		if (cc_event !== 4'h0) n_cc++;
		if (com_update_ch !== 4'h0) n_com++;
		cc_seen = cc_seen | cc_event;
		com_seen = com_seen | com_update_ch;
		if (cnt_load === 1'b1)
		begin
			n_upd++;
			load_seen = cnt_load_value;
		end
	end

	task stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask : check

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && i < 20)
		begin
			i++;
			@(posedge clk_sys);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
		if (i >= 20)
		begin
			n_fail++;
			stop_test();
		end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(name, rdat, exp);
	endtask : rd_chk

	// Event pulses land one edge after the write edge; four cycles cover them
	task fire(input logic [31:0] ev);
		n_brk = 0;
		n_trg = 0;
		n_upd = 0;
		n_presc = 0;
		n_cc = 0;
		n_com = 0;
		cc_seen = 4'h0;
		com_seen = 4'h0;
		wr(TSE_ADDR_EVTGEN, ev);
		repeat (4) @(posedge clk_sys);
	endtask : fire

	task ev_check(input int brk, input int trg, input int com, input int upd, input int cc);
		check("break pulses", n_brk, brk);
		check("trigger pulses", n_trg, trg);
		check("commutation pulses", n_com, com);
		check("update loads", n_upd, upd);
		check("prescaler clears", n_presc, upd);
		check("channel event pulses", n_cc, cc);
	endtask : ev_check

	task clr_status();
		wr(TSE_ADDR_STATUS, 32'h0000_1FFF);
	endtask : clr_status

	logic [11:0] uctrl [7] = '{12'h000, 12'h008, 12'h010, 12'h018, 12'h001, 12'h002, 12'h009};
	logic [31:0] expect_load;

	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rd_chk("ctrl reset", TSE_ADDR_CTRL, 32'h0000_0000);
		rd_chk("mask reset", TSE_ADDR_MASK, 32'h0000_0000);
		rd_chk("status reset", TSE_ADDR_STATUS, 32'h0000_0000);
		rd_chk("event reg reset", TSE_ADDR_EVTGEN, 32'h0000_0000);
		rd_chk("cap1 reset", TSE_ADDR_CAP1, 32'h0000_0000);
		check("irq reset", irq, 1'b0);
		rd_chk("unmapped read", 8'h40, 32'h0000_0000);
		check("unmapped error", rerr, 1'b1);
		// A zero write must do nothing; reserved bits are always written as zero
		fire(32'h0000_0000);
		ev_check(0, 0, 0, 0, 0);
		rd_chk("status idle", TSE_ADDR_STATUS, 32'h0000_0000);
		// Update in up, down and CMS 01 counting modes, and flag gating
		cnt_value <= 16'h5555;
		auto_reload_value <= 16'h0F3C;
		for (int k = 0; k < 7; k++)
		begin
			wr(TSE_ADDR_CTRL, {20'h0_0000, uctrl[k]});
			clr_status();
			fire(32'h0000_0001);
			ev_check(0, 0, 0, 1, 0);
			expect_load = (uctrl[k][3] && uctrl[k][5:4] == 2'b00) ? 32'h0000_0F3C : 32'h0000_0000;
			check("update load value", {16'h0000, load_seen}, expect_load);
			rd_chk("update flag", TSE_ADDR_STATUS, {31'h0000_0000, uctrl[k][1:0] == 2'b00});
		end
		// Break with its interrupt unmasked
		wr(TSE_ADDR_CTRL, 32'h0000_0000);
		clr_status();
		wr(TSE_ADDR_MASK, 32'h0000_0080);
		fire(32'h0000_0080);
		ev_check(1, 0, 0, 0, 0);
		rd_chk("break flag", TSE_ADDR_STATUS, 32'h0000_0080);
		check("break irq", irq, 1'b1);
		clr_status();
		repeat (2) @(posedge clk_sys);
		check("irq after clear", irq, 1'b0);
		// Trigger while masked, then unmasked
		fire(32'h0000_0040);
		ev_check(0, 1, 0, 0, 0);
		rd_chk("trigger flag", TSE_ADDR_STATUS, 32'h0000_0040);
		check("trigger masked irq", irq, 1'b0);
		wr(TSE_ADDR_MASK, 32'h0000_0040);
		repeat (2) @(posedge clk_sys);
		check("trigger irq", irq, 1'b1);
		// Commutation with and without preload control
		wr(TSE_ADDR_CTRL, 32'h0000_0004);
		clr_status();
		fire(32'h0000_0020);
		ev_check(0, 0, 1, 0, 0);
		check("commutation channels", com_seen, TSE_COMP_MASK);
		rd_chk("commutation flag", TSE_ADDR_STATUS, 32'h0000_0020);
		wr(TSE_ADDR_CTRL, 32'h0000_0000);
		fire(32'h0000_0020);
		check("commutation no preload", com_seen, 4'h0);
		// Output-mode channels, all at once
		clr_status();
		fire(32'h0000_001E);
		ev_check(0, 0, 0, 0, 1);
		check("channel events", cc_seen, 4'hF);
		rd_chk("channel flags", TSE_ADDR_STATUS, 32'h0000_001E);
		// Input-mode channels: capture, then overcapture
		wr(TSE_ADDR_CTRL, 32'h0000_0F00);
		clr_status();
		cnt_value <= 16'h1234;
		fire(32'h0000_001E);
		check("input mode events", cc_seen, 4'h0);
		rd_chk("capture flags", TSE_ADDR_STATUS, 32'h0000_001E);
		cnt_value <= 16'hBEEF;
		fire(32'h0000_001E);
		rd_chk("overcapture flags", TSE_ADDR_STATUS, 32'h0000_1E1E);
		for (int c = 0; c < 4; c++)
			rd_chk("capture value", TSE_ADDR_CAP1 + 8'(4 * c), 32'h0000_BEEF);
		// Every request in one write
		wr(TSE_ADDR_CTRL, 32'h0000_0000);
		clr_status();
		fire(32'h0000_00FF);
		ev_check(1, 1, 0, 1, 1);
		rd_chk("all flags", TSE_ADDR_STATUS, 32'h0000_00FF);
		rd_chk("event reg reads zero", TSE_ADDR_EVTGEN, 32'h0000_0000);
		stop_test();
	end
endmodule : tse_top_tb
